// ---- design/els_reply_regs.svh ----
// Purpose: constants for the link service reply builder
// Assumes: 32-bit payload words, 24-bit port identifiers
// Notes: definitions only
`ifndef ELS_REPLY_REGS_SVH
`define ELS_REPLY_REGS_SVH
`define ACC_CMD_BYTE 8'h02
`define RJT_CMD_WORD 32'h01000000
`define LAST_SEQ_BIT 20
`define RSN_CODE_LSB 16
`define RSN_EXPL_LSB 8
`define RSN_VEND_LSB 0
`define RC_BAD_CMD 8'h01
`define RC_LOGICAL 8'h03
`define RC_BUSY 8'h05
`define RC_PROTOCOL 8'h07
`define RC_UNABLE 8'h09
`define RC_UNSUPPORTED 8'h0B
`define RC_IN_PROGRESS 8'h0E
`define RC_FIP 8'h20
`define RC_VENDOR 8'hFF
`define RX_NONE 8'h00
`define RX_OPTIONS 8'h01
`define RX_INIT_CTL 8'h03
`define RX_RECIP_CTL 8'h05
`define RX_RX_SIZE 8'h07
`define RX_CONC_SEQ 8'h09
`define RX_CREDIT 8'h0B
`define RX_PORT_NAME 8'h0D
`define RX_NODE_NAME 8'h0E
`define RX_COMMON 8'h0F
`define RX_REQ_BUSY 8'h19
`define RX_LOGIN_REQ 8'h1E
`define RX_PORT_ID 8'h1F
`endif

// ---- design/els_reply_pkg.sv ----
// Purpose: types for the link service reply builder
// Assumes: nothing beyond the constants header
// Notes: error index order is the detection priority
package els_reply_pkg;
  // error conditions, lowest index checked first
  typedef enum logic [3:0] {
    ERR_BAD_CMD = 4'h0, ERR_LOGICAL = 4'h1, ERR_BUSY = 4'h2, ERR_PROTOCOL = 4'h3,
    ERR_UNABLE = 4'h4, ERR_UNSUPPORTED = 4'h5, ERR_IN_PROGRESS = 4'h6,
    ERR_FIP = 4'h7, ERR_VENDOR = 4'h8
  } err_t;
  typedef enum logic [1:0] {IDLE = 2'b00, WORD0 = 2'b01, WORD1 = 2'b11} state_t;
  // one request to answer
  typedef struct packed {
    logic [23:0] req_src;
    logic [23:0] req_dst;
    logic [8:0] err_flags;
    logic [7:0] expl;
    logic [7:0] vendor;
    logic [23:0] acc_tail;
  } req_t;
  // one payload word on the way out
  typedef struct packed {
    logic [23:0] d_id;
    logic [23:0] s_id;
    logic [31:0] data;
    logic [23:0] f_ctl;
    logic last;
    logic reject;
  } word_t;
endpackage : els_reply_pkg

// ---- design/els_reply_builder.sv ----
// Purpose: builds accept or reject reply payload words for a link service request
// Assumes: request and word sink on clk; framing and sending done downstream
//   all inputs come from logic on clk, so none passes a synchroniser
// Notes: accept carries only the command word; per-request tail comes in acc_tail
//   reason fields are resolved at take, so a stalled word never changes
`timescale 1ns/1ps
`include "els_reply_regs.svh"
module els_reply_builder (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input els_reply_pkg::req_t req,
  // reply word side
  output logic out_valid,
  input wire logic out_ready,
  output els_reply_pkg::word_t out_word,
  // completion
  output logic done_q
);
  // explanation codes a reject may carry besides none
  localparam int NUM_EXPL = 12;
  // error conditions, one flag each, lowest index detected first
  localparam int NUM_ERR = 9;

  // sequencer and the word on offer
  els_reply_pkg::state_t state_q;
  els_reply_pkg::word_t word_q;
  // reason fields resolved once at take
  logic [7:0] code_q;
  logic [7:0] expl_q;
  logic [7:0] vend_q;
  // handshake decode
  logic take;
  logic fire;
  logic last_taken;
  logic rsn_due;
  // reason fields of the request on the input
  logic [7:0] code_d;
  logic [7:0] expl_d;
  logic [7:0] vend_d;
  // priority chain and lookup terms
  wire [NUM_ERR-1:0] first_hit;
  wire [NUM_ERR-1:0] seen_below;
  wire [NUM_EXPL-1:0] expl_hit;
  wire [7:0] code_term [NUM_ERR];

  // reason code of one error index; spare index codes cannot be flagged
  function automatic logic [7:0] code_of(input logic [3:0] idx);
    logic [7:0] c;
    c = 8'h00;
    case (idx)
      // request content faults
      els_reply_pkg::ERR_BAD_CMD: begin
        c = `RC_BAD_CMD;
      end
      els_reply_pkg::ERR_LOGICAL: begin
        c = `RC_LOGICAL;
      end
      // recipient state faults
      els_reply_pkg::ERR_BUSY: begin
        c = `RC_BUSY;
      end
      els_reply_pkg::ERR_PROTOCOL: begin
        c = `RC_PROTOCOL;
      end
      els_reply_pkg::ERR_UNABLE: begin
        c = `RC_UNABLE;
      end
      els_reply_pkg::ERR_UNSUPPORTED: begin
        c = `RC_UNSUPPORTED;
      end
      els_reply_pkg::ERR_IN_PROGRESS: begin
        c = `RC_IN_PROGRESS;
      end
      // codes outside the base set
      els_reply_pkg::ERR_FIP: begin
        c = `RC_FIP;
      end
      els_reply_pkg::ERR_VENDOR: begin
        c = `RC_VENDOR;
      end
      default: begin
        c = 8'h00;
      end
    endcase
    return c;
  endfunction : code_of

  // listed explanation codes, one per index; anything else means none
  function automatic logic [7:0] expl_at(input logic [3:0] idx);
    logic [7:0] e;
    e = `RX_NONE;
    case (idx)
      // login service parameter faults
      4'h0: begin
        e = `RX_OPTIONS;
      end
      4'h1: begin
        e = `RX_INIT_CTL;
      end
      4'h2: begin
        e = `RX_RECIP_CTL;
      end
      4'h3: begin
        e = `RX_RX_SIZE;
      end
      4'h4: begin
        e = `RX_CONC_SEQ;
      end
      4'h5: begin
        e = `RX_CREDIT;
      end
      // name and common parameter faults
      4'h6: begin
        e = `RX_PORT_NAME;
      end
      4'h7: begin
        e = `RX_NODE_NAME;
      end
      4'h8: begin
        e = `RX_COMMON;
      end
      // request state faults
      4'h9: begin
        e = `RX_REQ_BUSY;
      end
      4'hA: begin
        e = `RX_LOGIN_REQ;
      end
      4'hB: begin
        e = `RX_PORT_ID;
      end
      default: begin
        e = `RX_NONE;
      end
    endcase
    return e;
  endfunction : expl_at

  // first word of either reply, built from the request being taken
  function automatic els_reply_pkg::word_t head_word(input els_reply_pkg::req_t r);
    els_reply_pkg::word_t w;
    w = '0;
    // identities swapped from the request
    w.d_id = r.req_src;
    w.s_id = r.req_dst;
    w.reject = (r.err_flags != 9'h000);
    if (w.reject) begin
      // reject opens with its fixed command word, reason follows next
      w.data = `RJT_CMD_WORD;
    end else begin
      // accept is a single word and closes the exchange
      w.data = {`ACC_CMD_BYTE, r.acc_tail};
      w.last = 1'b1;
      w.f_ctl[`LAST_SEQ_BIT] = 1'b1;
    end
    return w;
  endfunction : head_word

  // second reject word: ids kept, reason word replaces the command word
  function automatic els_reply_pkg::word_t reason_word(
    input els_reply_pkg::word_t head,
    input logic [7:0] code,
    input logic [7:0] expl,
    input logic [7:0] vend
  );
    els_reply_pkg::word_t w;
    w = head;
    // top byte is reserved and stays zero
    w.data = 32'h00000000;
    w.data[`RSN_CODE_LSB +: 8] = code;
    w.data[`RSN_EXPL_LSB +: 8] = expl;
    w.data[`RSN_VEND_LSB +: 8] = vend;
    w.last = 1'b1;
    return w;
  endfunction : reason_word

  // priority chain: a flag counts only when no lower index is set
  assign seen_below[0] = 1'b0;
  for (genvar i = 0; i < NUM_ERR; i++) begin : g_first
    assign first_hit[i] = req.err_flags[i] && !seen_below[i];
    assign code_term[i] = first_hit[i] ? code_of(4'(i)) : 8'h00;
    // the top flag ends the chain; nothing reads past it
    if (i < NUM_ERR - 1) begin : g_chain
      assign seen_below[i + 1] = seen_below[i] || req.err_flags[i];
    end
  end

  // explanation passes only when it is one of the listed codes
  for (genvar k = 0; k < NUM_EXPL; k++) begin : g_expl
    assign expl_hit[k] = (req.expl == expl_at(4'(k)));
  end

  // one-hot select, so or-ing the terms yields the single reported code
  always_comb begin
    code_d = 8'h00;
    for (int i = 0; i < NUM_ERR; i++) begin
      code_d = code_d | code_term[i];
    end
  end

  // unlisted explanations collapse to none; vendor byte only with vendor reason
  assign expl_d = (|expl_hit) ? req.expl : `RX_NONE;
  assign vend_d = first_hit[els_reply_pkg::ERR_VENDOR] ? req.vendor : 8'h00;

  // handshakes; clock enable gates every transfer
  assign req_ready = (state_q == els_reply_pkg::IDLE) && clk_en;
  assign take = req_valid && req_ready;
  assign fire = out_valid && out_ready && clk_en;
  assign last_taken = fire && word_q.last;
  assign rsn_due = fire && (state_q == els_reply_pkg::WORD0) && word_q.reject;

  // offered word comes straight from its register
  assign out_valid = (state_q != els_reply_pkg::IDLE);
  assign out_word = word_q;

  // sequencer: accept is one word, reject two; a stall holds the state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= els_reply_pkg::IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        els_reply_pkg::IDLE: begin
          // a request waits here until the previous reply is out
          if (req_valid) begin
            state_q <= els_reply_pkg::WORD0;
          end
        end
        els_reply_pkg::WORD0: begin
          // reject goes on to its reason word
          if (out_ready) begin
            state_q <= word_q.reject ? els_reply_pkg::WORD1 : els_reply_pkg::IDLE;
          end
        end
        els_reply_pkg::WORD1: begin
          // reason word is the closing word
          if (out_ready) begin
            state_q <= els_reply_pkg::IDLE;
          end
        end
        // the one spare code is never entered; fall back to idle
        default: begin
          state_q <= els_reply_pkg::IDLE;
        end
      endcase
    end
  end

  // reason fields resolved once per request, so a stall cannot change them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= 8'h00;
      expl_q <= 8'h00;
      vend_q <= 8'h00;
    end else if (take) begin
      code_q <= code_d;
      expl_q <= expl_d;
      vend_q <= vend_d;
    end
  end

  // word on offer: head word at take, reason word once the head is taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= '0;
    end else if (take) begin
      word_q <= head_word(req);
    end else if (rsn_due) begin
      word_q <= reason_word(word_q, code_q, expl_q, vend_q);
    end
  end

  // completion pulse the cycle after the closing word is taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= last_taken;
    end
  end
endmodule : els_reply_builder

// ---- sim/els_reply_chk.sv ----
// Purpose: port checker for the reply builder
// Assumes: bound to the builder top
// Notes: ids judged against the last taken request
`timescale 1ns/1ps
module els_reply_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // request side
  input wire logic req_valid,
  input wire logic req_ready,
  input els_reply_pkg::req_t req,
  // reply side
  input wire logic out_valid,
  input wire logic out_ready,
  input els_reply_pkg::word_t out_word,
  input wire logic done_q
);
  els_reply_pkg::req_t r_q;
  wire acc = out_valid && !out_word.reject;
  wire rjt = out_valid && out_word.reject;
  wire [31:0] d = out_word.data;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence take_s; req_valid && req_ready && clk_en; endsequence
  sequence end_s; out_valid && out_ready && clk_en && out_word.last; endsequence
  // request kept for the id checks
  always_ff @(posedge clk) if (req_valid && req_ready && clk_en) r_q <= req;
  a_take_answer: assert property (take_s |=> out_valid)
    else $error("no reply");
  a_end_done: assert property (end_s |=> done_q)
    else $error("no done");
  a_acc_last: assert property (acc |-> out_word.last && out_word.f_ctl[20])
    else $error("accept not last");
  a_acc_cmd: assert property (acc |-> d[31:24] == 8'h02)
    else $error("accept command");
  a_reply_ids: assert property (out_valid |->
    out_word.d_id == r_q.req_src && out_word.s_id == r_q.req_dst) else $error("ids");
  a_rjt_cmd: assert property (rjt && !out_word.last |-> d == 32'h01000000)
    else $error("reject command");
  a_rsn_field: assert property (rjt && out_word.last |-> d[31:24] == 8'h00 &&
    d[23:16] inside {8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0E, 8'h20, 8'hFF})
    else $error("reason");
  a_word_hold: assert property (out_valid && !(out_ready && clk_en) |=> $stable(out_word))
    else $error("word moved");
  a_done_pulse: assert property (done_q && clk_en |=> !done_q)
    else $error("done held");
  a_busy_refuse: assert property (out_valid |-> !req_ready)
    else $error("request taken while busy");
endmodule : els_reply_chk

// ---- sim/reply_sink.sv ----
// Purpose: far port model taking reply words
// Assumes: it may stall any cycle
// Notes: ready is prompt most cycles
`timescale 1ns/1ps
module reply_sink (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // reply handshake
  input wire logic out_valid,
  output logic out_ready
);
  // random stalls make the builder hold its word
  initial out_ready = 1'b0;
  always @(posedge clk) out_ready <= reset_n && !(out_valid && $urandom_range(0, 3) == 0);
endmodule : reply_sink

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench of the reply builder
// Assumes: sink model drives out_ready
// Notes: corner flags first, then random ones
`timescale 1ns/1ps
module tb_top;
  logic clk, reset_n, clk_en, req_valid, req_ready, out_valid, out_ready, done_q;
  els_reply_pkg::req_t req, r;
  els_reply_pkg::word_t out_word, w, exp_q[$];
  int num_errors = 0, tests_run = 0;
  els_reply_builder u_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word), .done_q(done_q));
  reply_sink u_sink (.clk(clk), .reset_n(reset_n), .out_valid(out_valid), .out_ready(out_ready));
  task automatic fail(string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // lowest flagged index wins; unlisted explanation stays zero
  function automatic logic [31:0] rsn(els_reply_pkg::req_t q);
    logic [7:0] rc [9] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0E, 8'h20, 8'hFF};
    rsn = 32'h00000000;
    for (int i = 8; i >= 0; i--) if (q.err_flags[i]) rsn[23:16] = rc[i];
    if (q.expl inside {8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, [8'h0D:8'h0F], 8'h19,
      8'h1E, 8'h1F}) rsn[15:8] = q.expl;
    if (rsn[23:16] == 8'hFF) rsn[7:0] = q.vendor;
  endfunction : rsn
  // queue expected words, hold the request until taken
  task automatic send(els_reply_pkg::req_t q);
    int n = 0;
    if (q.err_flags == 9'h000) exp_q.push_back('{q.req_src, q.req_dst, {8'h02, q.acc_tail},
      24'h100000, 1'b1, 1'b0});
    else begin
      exp_q.push_back('{q.req_src, q.req_dst, 32'h01000000, 24'h0, 1'b0, 1'b1});
      exp_q.push_back('{q.req_src, q.req_dst, rsn(q), 24'h0, 1'b1, 1'b1});
    end
    req <= q;
    req_valid <= 1'b1;
    do @(posedge clk); while (!(req_ready && clk_en) && ++n < 50);
    if (n == 50) fail("request not taken");
  endtask : send
  // each word taken by the sink against the oldest expected one
  always @(posedge clk) if (reset_n && out_valid && out_ready && clk_en) begin
    w = out_word;
    w.f_ctl &= 24'h100000;
    tests_run++;
    if (exp_q.size() == 0 || w !== exp_q[0]) fail("reply word");
    if (exp_q.size() > 0) void'(exp_q.pop_front());
  end
  always @(posedge clk) clk_en <= $urandom_range(0, 7) != 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    fail("timeout");
    results();
  end
  initial begin
    {reset_n, clk_en, req_valid} = 3'h2;
    req = '0;
    void'($urandom(69));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      r = 97'({$urandom(), $urandom(), $urandom(), $urandom()});
      if (i < 14) r.err_flags = i < 9 ? 9'h001 << i : 9'h000;
      r.expl = 8'($urandom_range(0, 47));
      send(r);
    end
    req_valid <= 1'b0;
    for (int n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge clk);
    if (exp_q.size() > 0) fail("words missing");
    results();
  end
endmodule : tb_top
bind els_reply_builder els_reply_chk u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .out_valid(out_valid),
  .out_ready(out_ready), .out_word(out_word), .done_q(done_q));
